// [include/sarcc_defines.svh]
// Constants of the SAR conversion control block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef SARCC_DEFINES_SVH
`define SARCC_DEFINES_SVH

// Result width and shift chain depth
`define SARCC_BITS        8
// Clocks per phase cycle, one bit decision each
`define SARCC_PHASES      8
`define SARCC_PHASE_LAST  3'h7
`define SARCC_PHASE_RST   3'h0
// Conversion length, clock periods from start to completion
`define SARCC_CONV_MIN    62
`define SARCC_CONV_MAX    73
// Longest wait for proper phases after an asynchronous start
`define SARCC_START_WAIT  8
// Codes
`define SARCC_CODE_ZERO   8'h00
`define SARCC_CODE_MSB    8'h80
`define SARCC_CODE_FULL   8'hFF

`endif

// [include/sarcc_pkg.sv]
// Types of the SAR conversion control block.
// Assumes sarcc_defines.svh is on the include path.
`include "sarcc_defines.svh"

package sarcc_pkg;
	typedef logic [`SARCC_BITS-1:0] sarcc_code_type;
	typedef logic [`SARCC_BITS-1:0] sarcc_stage_type;
	typedef logic [2:0]             sarcc_phase_type;
endpackage : sarcc_pkg

// [verilog/sarcc_sync.sv]
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are static relative to mclk_i only by chance.
`timescale 1ns/10ps
`include "sarcc_defines.svh"

module sarcc_sync #(
	parameter int      WIDTH = 1,
	parameter logic    RST_VAL = 1'b1
) (
	input  wire logic             mclk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta   <= {WIDTH{RST_VAL}};
			sync_o <= {WIDTH{RST_VAL}};
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule // sarcc_sync

// [verilog/sarcc_shift_chain.sv]
// Shift chain that walks a single one through the bit stages.
// Assumes tick_i pulses once per phase cycle on mclk_i.
`timescale 1ns/10ps
`include "sarcc_defines.svh"

module sarcc_shift_chain #(
	parameter int STAGES = `SARCC_BITS
) (
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              clear_i,
	input  wire logic              tick_i,
	input  wire logic              load_one_i,
	output logic      [STAGES-1:0] stage_o,
	output logic                   leave_o
);
	// One leaves the last stage on this tick
	assign leave_o = tick_i & stage_o[STAGES-1];

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stage_o <= '0;
		end else if (clear_i) begin
			stage_o <= '0;
		end else if (tick_i) begin
			stage_o <= {stage_o[STAGES-2:0], load_one_i};
		end
	end
endmodule // sarcc_shift_chain

// [verilog/sarcc_top.sv]
// Control logic of an 8-bit successive-approximation converter:
// start flip-flop, shift chain, output latch, completion flag, read.
// Assumes an external comparator answers the trial code on trial_o.
//
// Contract
// - Negative input at or above positive input yields an all-zero code.
// - Asynchronous start may wait up to 8 clocks for proper phases.
// - Start strobe of any length holds reset; rising edge launches.
// - MSB first, 8 comparisons in 64 clocks, then latch result.
// - Start falling edge clears SAR, stages, and raises completion output.
// - While select and start both low, stay in reset.
// - Conversion begins 1 to 8 clocks after select or start rises.
// - Completion output falls when a conversion finishes.
// - Read with select low returns completion output high.
// - A new start during conversion abandons it and restarts.
// - Select and start low set start flip-flop, clearing chain and flag.
// - Gated pulse clears start flip-flop only once strobe released.
// - One leaving last stage loads latch; next clock sets flag.
// - Select and read low clear flag and drive data, else float.
// - Completion pin is inverse of the completion flip-flop.
// - Start to completion takes 62 to 73 clock periods.
`timescale 1ns/10ps
`include "sarcc_defines.svh"

module sarcc_top #(
	parameter int BITS = `SARCC_BITS
) (
	input  wire logic              mclk_i,
	input  wire logic              rstn_i,
	input  wire logic              select_n_i,
	input  wire logic              start_n_i,
	input  wire logic              read_n_i,
	input  wire logic              comp_ge_i,
	input  wire logic              neg_ge_pos_i,
	output sarcc_pkg::sarcc_code_type trial_o,
	output sarcc_pkg::sarcc_code_type data_o,
	output logic                   data_oe_n_o,
	output logic                   conversion_done_n_o
);
	import sarcc_pkg::*;

	localparam int WAIT_MAX = `SARCC_START_WAIT;
	localparam int CONV_MIN = `SARCC_CONV_MIN;
	localparam int CONV_MAX = `SARCC_CONV_MAX;

	logic            rst_meta;
	logic            rst_n;
	logic [3:0]      pins_s;
	logic            select_n_s;
	logic            start_n_s;
	logic            read_n_s;
	logic            comp_s;
	logic            neg_s;
	logic            set_req;
	logic            read_act;
	sarcc_phase_type phase;
	logic            tick;
	logic            start_ff;
	logic            first_stage_ff;
	logic            start_clear_gate;
	sarcc_stage_type stage;
	logic            latch_load_gate;
	logic            done_stage_ff;
	logic            done_ff;
	sarcc_code_type  sar;
	sarcc_code_type  next_sar;
	sarcc_code_type  result_latch;
	logic            bit_keep;

	////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Comparator also crosses; it settles within a phase cycle anyway
	sarcc_sync #(
		.WIDTH   (4),
		.RST_VAL (1'b1)
	) u_pin_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n),
		.async_i ({select_n_i, start_n_i, read_n_i, comp_ge_i}),
		.sync_o  (pins_s)
	);

	sarcc_sync #(
		.WIDTH   (1),
		.RST_VAL (1'b0)
	) u_neg_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n),
		.async_i (neg_ge_pos_i),
		.sync_o  (neg_s)
	);

	assign select_n_s = pins_s[3];
	assign start_n_s  = pins_s[2];
	assign read_n_s   = pins_s[1];
	assign comp_s     = pins_s[0];
	assign set_req    = ~select_n_s & ~start_n_s;
	assign read_act   = ~select_n_s & ~read_n_s;

	////////////////////////////////////////////////////////////////////
	// Free-running phase counter

	// Phases never realign to the strobe
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			phase <= `SARCC_PHASE_RST;
		end else begin
			phase <= phase + 3'h1;
		end
	end

	assign tick = (phase == `SARCC_PHASE_LAST);

	////////////////////////////////////////////////////////////////////
	// Start flip-flop and first stage

	// Gated clear, ineffective while set held
	assign start_clear_gate = first_stage_ff & tick & ~set_req;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			start_ff <= 1'b0;
		end else if (set_req) begin
			start_ff <= 1'b1;
		end else if (start_clear_gate) begin
			start_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			first_stage_ff <= 1'b0;
		end else begin
			first_stage_ff <= start_ff & ~start_clear_gate;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bit stage chain

	sarcc_shift_chain #(
		.STAGES     (BITS)
	) u_chain (
		.mclk_i     (mclk_i),
		.rst_n_i    (rst_n),
		.clear_i    (set_req | (start_ff & ~start_clear_gate)),
		.tick_i     (tick),
		.load_one_i (start_clear_gate),
		.stage_o    (stage),
		.leave_o    (latch_load_gate)
	);

	////////////////////////////////////////////////////////////////////
	// Approximation register

	// Keep only if input at or above trial
	assign bit_keep = comp_s & ~neg_s;

	always_comb begin
		next_sar = sar;
		for (int i = 0; i < BITS; i++) begin
			if (stage[i]) begin
				next_sar[BITS-1-i] = bit_keep;
				if (i < BITS-1) begin
					next_sar[BITS-2-i] = 1'b1;
				end
			end
		end
	end

	// MSB trial first, cleared by start
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			sar <= `SARCC_CODE_ZERO;
		end else if (set_req | start_ff & ~start_clear_gate) begin
			sar <= `SARCC_CODE_ZERO;
		end else if (start_clear_gate) begin
			sar <= `SARCC_CODE_MSB;
		end else if (tick) begin
			sar <= next_sar;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			trial_o <= `SARCC_CODE_ZERO;
		end else begin
			trial_o <= sar;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Output latch and completion

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_latch <= `SARCC_CODE_ZERO;
		end else if (latch_load_gate) begin
			result_latch <= next_sar;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			done_stage_ff <= 1'b0;
		end else begin
			done_stage_ff <= latch_load_gate;
		end
	end

	// Start clear wins, set beats read
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			done_ff <= 1'b0;
		end else if (set_req) begin
			done_ff <= 1'b0;
		end else if (done_stage_ff) begin
			done_ff <= 1'b1;
		end else if (read_act) begin
			done_ff <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			conversion_done_n_o <= 1'b1;
		end else begin
			conversion_done_n_o <= ~done_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path; the pad resolves float from data_oe_n_o

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			data_o      <= `SARCC_CODE_ZERO;
			data_oe_n_o <= 1'b1;
		end else begin
			data_o      <= read_act ? result_latch : `SARCC_CODE_ZERO;
			data_oe_n_o <= ~read_act;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks

	int  conv_cnt;
	logic neg_all;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			conv_cnt <= 0;
			neg_all  <= 1'b0;
		end else if (start_clear_gate) begin
			conv_cnt <= 1;
			neg_all  <= 1'b1;
		end else begin
			if (conv_cnt < 255) begin
				conv_cnt <= conv_cnt + 1;
			end
			if (tick && (stage != '0) && !neg_s) begin
				neg_all <= 1'b0;
			end
		end
	end

	AST_ZERO_CODE: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		latch_load_gate && neg_all && neg_s
		|=> result_latch == `SARCC_CODE_ZERO)
		else $error("zero code not produced");

	AST_START_WAIT: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		$fell(set_req) && start_ff
		|-> ##[1:WAIT_MAX] (stage[0] || set_req))
		else $error("conversion did not begin in time");

	AST_HOLD: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		set_req |=> (stage == '0) && (sar == `SARCC_CODE_ZERO)
			&& !done_ff && start_ff)
		else $error("held start did not reset chain");

	AST_MSB_FIRST: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		$rose(stage[0]) |-> sar == `SARCC_CODE_MSB)
		else $error("first trial is not the top bit");

	AST_CONV_LEN: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		$rose(done_ff) |-> conv_cnt >= CONV_MIN && conv_cnt <= CONV_MAX)
		else $error("conversion length out of range");

	AST_STAGE_STEP: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		$rose(stage[1]) |-> $past(stage[0], 8) && !set_req)
		else $error("bit stage did not last eight clocks");

	AST_LATCH_DONE: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		latch_load_gate && !set_req ##1 !set_req |->
			done_stage_ff ##1 done_ff)
		else $error("completion not set after latch load");

	AST_DONE_PIN: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		##1 conversion_done_n_o == !$past(done_ff))
		else $error("completion pin not inverse of flag");

	AST_READ_CLR: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		read_act && !done_stage_ff |=> ##1 conversion_done_n_o)
		else $error("read did not raise completion pin");

	AST_DRIVE: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		read_act |=> !data_oe_n_o && data_o == $past(result_latch))
		else $error("read data not driven");

	AST_FLOAT: assert property (@(posedge mclk_i)
		disable iff (!rst_n)
		!read_act |=> data_oe_n_o)
		else $error("data driven outside read");

	COV_DONE: cover property (@(posedge mclk_i) disable iff (!rst_n)
		$fell(conversion_done_n_o));
	COV_READ: cover property (@(posedge mclk_i) disable iff (!rst_n)
		done_ff && read_act);
	COV_RESTART: cover property (@(posedge mclk_i) disable iff (!rst_n)
		(stage != '0) && set_req);
	COV_FULL: cover property (@(posedge mclk_i) disable iff (!rst_n)
		latch_load_gate && next_sar == `SARCC_CODE_FULL);
endmodule // sarcc_top

// [tb/sarcc_host_model.sv]
// Far-side model: start/read controller, comparator and data bus.
// Assumes the bench calls its tasks and sets level between conversions.
`timescale 1ns/10ps

module sarcc_host_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] trial_i,
	input  wire logic [7:0] data_i,
	input  wire logic       data_oe_n_i,
	input  wire logic       done_n_i,
	output logic            select_n_o,
	output logic            start_n_o,
	output logic            read_n_o,
	output logic            comp_ge_o,
	output logic      [7:0] bus_o
);
	logic [7:0] level;
	logic [7:0] last;
	logic       free;

	initial begin
		free = 1'b0;
		select_n_o = 1'b1;
		start_n_o = 1'b1;
		read_n_o = 1'b1;
		comp_ge_o = 1'b0;
		level = 8'h00;
		last = 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Comparator: input at or above the trial level
	always @(posedge mclk_i) begin
		comp_ge_o <= (level >= trial_i);
	end

	// Released bus shows the inverse of the last value, never a stale copy
	always @(posedge mclk_i) begin
		if (!data_oe_n_i) begin
			last <= data_i;
		end
	end
	assign bus_o = data_oe_n_i ? ~last : data_i;

	// Free running: completion pin fed back to start
	always @(posedge mclk_i) begin
		if (free) begin
			start_n_o <= done_n_i;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic set_sel(input logic v);
		@(posedge mclk_i);
		select_n_o <= v;
	endtask

	task automatic start(input int width);
		@(posedge mclk_i);
		start_n_o <= 1'b0;
		repeat (width) @(posedge mclk_i);
		start_n_o <= 1'b1;
	endtask

	// Active-low read pulse, sampled once settled
	task automatic read(output logic [7:0] v, output logic oe_n);
		@(posedge mclk_i);
		read_n_o <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1;
		v = bus_o;
		oe_n = data_oe_n_i;
		@(posedge mclk_i);
		read_n_o <= 1'b1;
	endtask
endmodule // sarcc_host_model

// [tb/sarcc_top_tb.sv]
// Self-checking bench of the conversion control block.
// Assumes sarcc_host_model stands on the bus side and the comparator.
`timescale 1ns/10ps
`include "sarcc_defines.svh"

module sarcc_top_tb;
	// Sync stages and phase wait widen the window seen at the pins
	localparam int T_MIN = `SARCC_CONV_MIN;
	localparam int T_MAX = `SARCC_CONV_MAX + `SARCC_START_WAIT + 2;
	logic       mclk;
	logic       rstn;
	logic       neg_ge;
	logic       select_n;
	logic       start_n;
	logic       read_n;
	logic       comp_ge;
	logic [7:0] trial;
	logic [7:0] data;
	logic [7:0] bus;
	logic       data_oe_n;
	logic       done_n;
	int         miscompares;
	int         cmp_count;
	int         cycles;

	sarcc_top sarcc_top_inst (.mclk_i(mclk), .rstn_i(rstn),
		.select_n_i(select_n), .start_n_i(start_n), .read_n_i(read_n),
		.comp_ge_i(comp_ge), .neg_ge_pos_i(neg_ge), .trial_o(trial),
		.data_o(data), .data_oe_n_o(data_oe_n),
		.conversion_done_n_o(done_n));

	sarcc_host_model sarcc_host_model_inst (.mclk_i(mclk), .trial_i(trial),
		.data_i(data), .data_oe_n_i(data_oe_n), .done_n_i(done_n),
		.select_n_o(select_n),
		.start_n_o(start_n), .read_n_o(read_n), .comp_ge_o(comp_ge),
		.bus_o(bus));

	always #10 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (done_n !== 1'b0 && n < 150);
	endtask

	task automatic check_time(input int n);
		check("conv_time", 8'h01, (n >= T_MIN && n <= T_MAX) ? 8'h01 : 8'h00);
	endtask

	task automatic read_clear(input logic [7:0] exp);
		logic [7:0] v;
		logic       oe;
		sarcc_host_model_inst.read(v, oe);
		check("read_data", exp, v);
		check("read_oe_n", 8'h00, {7'h00, oe});
		repeat (3) @(posedge mclk);
		#1;
		check("done_after_read", 8'h01, {7'h00, done_n});
		check("oe_after_read", 8'h01, {7'h00, data_oe_n});
	endtask

	task automatic t_convert(input logic [7:0] lvl, input logic neg,
		input logic [7:0] exp);
		int n;
		sarcc_host_model_inst.level = lvl;
		@(posedge mclk);
		neg_ge <= neg;
		sarcc_host_model_inst.start(3);
		wait_done(n);
		check_time(n);
		check("done_n", 8'h00, {7'h00, done_n});
		read_clear(exp);
		neg_ge <= 1'b0;
		$display("test convert %h done", lvl);
	endtask

	task automatic t_hold();
		int n;
		int bad;
		bad = 0;
		sarcc_host_model_inst.level = 8'h5A;
		sarcc_host_model_inst.start(2);
		wait_done(n);
		fork
			sarcc_host_model_inst.start(40);
		join_none
		repeat (5) @(posedge mclk);
		#1;
		check("done_on_start", 8'h01, {7'h00, done_n});
		repeat (30) begin
			@(posedge mclk);
			#1;
			if (trial !== 8'h00 || done_n !== 1'b1) bad++;
		end
		check("held_idle", 8'h00, (bad != 0) ? 8'h01 : 8'h00);
		wait (start_n === 1'b1);
		wait_done(n);
		check_time(n);
		read_clear(8'h5A);
		$display("test hold done");
	endtask

	task automatic t_restart();
		int n;
		sarcc_host_model_inst.level = 8'h3C;
		sarcc_host_model_inst.start(2);
		repeat (30) @(posedge mclk);
		sarcc_host_model_inst.level = 8'hC3;
		sarcc_host_model_inst.start(2);
		wait_done(n);
		check_time(n);
		read_clear(8'hC3);
		$display("test restart done");
	endtask

	task automatic t_select();
		int         n;
		logic [7:0] v;
		logic       oe;
		sarcc_host_model_inst.level = 8'h81;
		sarcc_host_model_inst.set_sel(1'b1);
		sarcc_host_model_inst.start(3);
		sarcc_host_model_inst.read(v, oe);
		check("oe_unselected", 8'h01, {7'h00, oe});
		wait_done(n);
		check("no_start_unsel", 8'h01, {7'h00, done_n});
		sarcc_host_model_inst.set_sel(1'b0);
		fork
			sarcc_host_model_inst.start(20);
		join_none
		repeat (6) @(posedge mclk);
		sarcc_host_model_inst.set_sel(1'b1);
		wait_done(n);
		check_time(n);
		sarcc_host_model_inst.set_sel(1'b0);
		read_clear(8'h81);
		$display("test select done");
	endtask

	task automatic t_free();
		int n;
		sarcc_host_model_inst.level = 8'h96;
		sarcc_host_model_inst.start(2);
		wait_done(n);
		sarcc_host_model_inst.free = 1'b1;
		n = 0;
		while (done_n !== 1'b1 && n < 20) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("free_restart", 8'h01, {7'h00, done_n});
		wait_done(n);
		sarcc_host_model_inst.free = 1'b0;
		check_time(n);
		read_clear(8'h96);
		$display("test free run done");
	endtask

	task automatic conclude();
		$display("compares %0d miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Guard against a hang; full run is well under two thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		neg_ge = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (3) @(posedge mclk);
		rstn <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		check("reset_done_n", 8'h01, {7'h00, done_n});
		check("reset_oe_n", 8'h01, {7'h00, data_oe_n});
		sarcc_host_model_inst.set_sel(1'b0);
		repeat (3) @(posedge mclk);
		t_convert(8'hA5, 1'b0, 8'hA5);
		t_convert(`SARCC_CODE_FULL, 1'b0, `SARCC_CODE_FULL);
		t_convert(8'h00, 1'b0, `SARCC_CODE_ZERO);
		t_convert(8'h7F, 1'b0, 8'h7F);
		t_convert(`SARCC_CODE_FULL, 1'b1, `SARCC_CODE_ZERO);
		t_hold();
		t_restart();
		t_select();
		t_free();
		conclude();
	end
endmodule // sarcc_top_tb
